// ---- hw/oef_pkg.sv ----
package oef_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int LONG_SE0_TIME_US = 2000;
    localparam int IDLE_SUSPEND_TIME_US = 3000;
    localparam int LONG_SE0_CYCLES = LONG_SE0_TIME_US * CLK_MHZ;
    localparam int IDLE_SUSPEND_CYCLES = IDLE_SUSPEND_TIME_US * CLK_MHZ;
    // synchroniser fill plus one compare stage
    localparam int SETTLE_CYCLES = 3;
    localparam int SETTLE_W = 2;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] CMD_PENDING_RD = 8'h66;
    localparam logic [7:0] CMD_STATUS_RD = 8'h67;
    localparam logic [7:0] CMD_FLAGS_RD = 8'h68;
    localparam logic [7:0] CMD_IRQ_EN_RD = 8'h69;
    localparam logic [7:0] CMD_FLAGS_WR = 8'hE8;
    localparam logic [7:0] CMD_IRQ_EN_WR = 8'hE9;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int NUM_LEVELS = 6;
    localparam int NUM_EVENTS = 11;
    localparam int BIT_ID = 0;
    localparam int BIT_A_VBUS = 1;
    localparam int BIT_B_END = 2;
    localparam int BIT_A_SESS = 3;
    localparam int BIT_B_SESS = 4;
    localparam int BIT_RMT = 5;
    localparam int BIT_SUSPEND = 6;
    localparam int BIT_RESUME = 7;
    localparam int BIT_SRP = 8;
    localparam int BIT_SE0 = 9;
    localparam int BIT_TIMER = 10;
    localparam logic [15:0] EVENT_MASK = 16'h07FF;
    localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] RDATA_IDLE = 16'h0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // bit order equals flag bit order 5..0
    typedef struct packed {
        logic remote_connected;
        logic b_session_valid;
        logic a_session_valid;
        logic b_session_end;
        logic a_vbus_valid;
        logic id_pin_level;
    } oef_levels_t;

    typedef struct packed {
        logic timer_timeout;
        logic session_request;
    } oef_events_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } oef_bus_req_t;

endpackage

// ---- hw/oef_sync.sv ----
`timescale 1ns/1ns
module oef_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("oef_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // oef_sync

// ---- hw/oef_hold_timer.sv ----
`timescale 1ns/1ns
module oef_hold_timer #(
    parameter int LIMIT = 200000
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic cond,
    output logic hit
);
    localparam int CNT_W = $clog2(LIMIT + 2);
    localparam logic [CNT_W-1:0] LIMIT_CNT = CNT_W'(LIMIT);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic hit_r;
    wire at_limit = (cnt_r == LIMIT_CNT);
    wire past_limit = (cnt_r > LIMIT_CNT);

    if (LIMIT < 1) begin : g_bad_limit
        $error("oef_hold_timer: LIMIT must be at least 1");
    end

    // one pulse per run; saturates so a long run cannot re-fire
    assign cnt_nxt = !cond ? '0 : (past_limit ? cnt_r : cnt_r + 1'b1);

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= '0;
            hit_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            hit_r <= cond && at_limit;
        end
    end

    assign hit = hit_r;
endmodule // oef_hold_timer

// ---- hw/oef_top.sv ----
// What this block does
// - flag bit 2 sets on b_session_end change, write one clears, zero ignored.
// - flag bit 1 sets on a_vbus_valid change, write one clears, zero ignored.
// - flag bit 0 sets on id_pin_level change, write one clears, zero ignored.
// - enable register read 69h, write E9h; bits 10..0 reset zero, 15..11 reserved.
// - enable bit 10 passes timer timeout flag to interrupt.
// - enable bit 9 passes long SE0 flag to interrupt.
// - enable bit 8 passes session request flag to interrupt.
// - enable bit 7 passes resume (J to K only) flag to interrupt.
// - enable bit 6 passes suspend flag to interrupt.
// - enable bit 5 passes remote connection change flag to interrupt.
// - enable bit 4 passes b_session_valid change flag to interrupt.
// - enable bit 3 passes a_session_valid change flag to interrupt.
// - enable bit 2 passes b_session_end change flag to interrupt.
// - enable bit 1 passes a_vbus_valid change flag to interrupt.
// - enable bit 0 passes id_pin_level change flag to interrupt.
// - flag bit 10 sets on timer timeout, write one clears.
// - flag bit 9 sets after more than 2 ms of SE0, write one clears.
// - flag bit 6 sets on suspend entry after more than 3 ms idle.
// - flag bit 7 sets on J to K while suspended, write one clears.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module oef_top #(
    parameter int LONG_SE0_CYCLES = oef_pkg::LONG_SE0_CYCLES,
    parameter int IDLE_SUSPEND_CYCLES = oef_pkg::IDLE_SUSPEND_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire oef_pkg::oef_bus_req_t bus_req,
    output logic [oef_pkg::DATA_W-1:0] rdata,
    input wire oef_pkg::oef_levels_t levels_async,
    input wire oef_pkg::oef_events_t events,
    input wire logic dp_pin,
    input wire logic dm_pin,
    output logic otg_irq
);
    import oef_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (LONG_SE0_CYCLES < 1) begin : g_bad_se0
        $error("oef_top: LONG_SE0_CYCLES must be at least 1");
    end
    if (IDLE_SUSPEND_CYCLES < 1) begin : g_bad_idle
        $error("oef_top: IDLE_SUSPEND_CYCLES must be at least 1");
    end
    // register word, flag order and decode all lean on the package layout
    if (NUM_EVENTS > DATA_W) begin : g_bad_events
        $error("oef_top: NUM_EVENTS exceeds DATA_W");
    end
    if (NUM_LEVELS + 1 > DATA_W) begin : g_bad_levels
        $error("oef_top: status word exceeds DATA_W");
    end
    if (BIT_RMT != NUM_LEVELS - 1) begin : g_bad_order
        $error("oef_top: level struct order must match flag bits");
    end
    if (BIT_TIMER != NUM_EVENTS - 1) begin : g_bad_layout
        $error("oef_top: event bits must be packed from zero");
    end
    if (EVENT_MASK != DATA_W'((1 << NUM_EVENTS) - 1)) begin : g_bad_mask
        $error("oef_top: EVENT_MASK must cover exactly the event bits");
    end
    if ((IRQ_EN_RESET & ~EVENT_MASK) != '0) begin : g_bad_en_reset
        $error("oef_top: reserved enable bits must reset to zero");
    end
    if ((FLAGS_RESET & ~EVENT_MASK) != '0) begin : g_bad_fl_reset
        $error("oef_top: reserved flag bits must reset to zero");
    end
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > (1 << SETTLE_W)) begin : g_bad_settle
        $error("oef_top: SETTLE_CYCLES does not fit SETTLE_W");
    end
    if (ADDR_W != $bits(CMD_FLAGS_RD)) begin : g_bad_addr
        $error("oef_top: ADDR_W must match the command code width");
    end
    if (CMD_FLAGS_RD == CMD_IRQ_EN_RD || CMD_FLAGS_WR == CMD_IRQ_EN_WR) begin : g_bad_codes
        $error("oef_top: command codes must be distinct");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    oef_levels_t levels_sync;
    oef_levels_t levels_prev_r;
    logic [1:0] line_sync;
    logic [SETTLE_W-1:0] settle_r;
    logic settled_r;
    logic suspended_r;
    logic suspended_nxt;
    logic line_j_prev_r;
    logic long_se0_hit;
    logic idle_hit;
    logic [DATA_W-1:0] flags_r;
    logic [DATA_W-1:0] flags_nxt;
    logic [DATA_W-1:0] irq_en_r;
    logic [DATA_W-1:0] irq_en_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic otg_irq_r;
    logic otg_irq_nxt;
    logic [NUM_EVENTS-1:0] flag_set;
    logic [NUM_LEVELS-1:0] level_chg;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    oef_sync #(
        .WIDTH(NUM_LEVELS)
    ) u_level_sync (
        .clk(clk),
        .srst(srst),
        .async_in(levels_async),
        .sync_out(levels_sync)
    );

    oef_sync #(
        .WIDTH(2)
    ) u_line_sync (
        .clk(clk),
        .srst(srst),
        .async_in({dp_pin, dm_pin}),
        .sync_out(line_sync)
    );

    // ------------------------------------------------------------
    // settle window after reset
    // ------------------------------------------------------------
    // synchronisers come out of reset at zero; comparing against
    // them before they fill would flag every high level as a change
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);
    wire settle_done = (settle_r == SETTLE_LAST);

    always_ff @(posedge clk) begin
        if (srst) begin
            settle_r <= '0;
            settled_r <= 1'b0;
        end else begin
            settle_r <= settle_done ? settle_r : settle_r + 1'b1;
            settled_r <= settle_done;
        end
    end

    // ------------------------------------------------------------
    // status level change detection
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            levels_prev_r <= '0;
        end else begin
            levels_prev_r <= levels_sync;
        end
    end

    assign level_chg = settled_r ? (levels_sync ^ levels_prev_r) : '0;

    // ------------------------------------------------------------
    // bus line state
    // ------------------------------------------------------------
    wire line_dp = line_sync[1];
    wire line_dm = line_sync[0];
    wire line_se0 = !line_dp && !line_dm;
    wire line_j = line_dp && !line_dm;
    wire line_k = !line_dp && line_dm;

    oef_hold_timer #(
        .LIMIT(LONG_SE0_CYCLES)
    ) u_se0_timer (
        .clk(clk),
        .srst(srst),
        .cond(line_se0 && settled_r),
        .hit(long_se0_hit)
    );

    // idle timer stops once suspended, so suspend entry flags once
    oef_hold_timer #(
        .LIMIT(IDLE_SUSPEND_CYCLES)
    ) u_idle_timer (
        .clk(clk),
        .srst(srst),
        .cond(line_j && !suspended_r && settled_r),
        .hit(idle_hit)
    );

    // any non-idle line state ends suspend
    assign suspended_nxt = idle_hit ? 1'b1 : (suspended_r && line_j);

    always_ff @(posedge clk) begin
        if (srst) begin
            suspended_r <= 1'b0;
            line_j_prev_r <= 1'b0;
        end else begin
            suspended_r <= suspended_nxt;
            line_j_prev_r <= line_j;
        end
    end

    // only a direct J to K counts; SE0 or a J to SE0 wake is ignored
    wire resume_seen = suspended_r && line_j_prev_r && line_k;

    // ------------------------------------------------------------
    // event flag sources
    // ------------------------------------------------------------
    wire id_pin_changed = level_chg[BIT_ID];
    wire a_vbus_valid_changed = level_chg[BIT_A_VBUS];
    wire b_session_end_changed = level_chg[BIT_B_END];
    wire a_session_valid_changed = level_chg[BIT_A_SESS];
    wire b_session_valid_changed = level_chg[BIT_B_SESS];
    wire remote_connect_changed = level_chg[BIT_RMT];
    wire suspend_flag = idle_hit;
    wire resume_flag = resume_seen;
    wire session_request_flag = events.session_request;
    wire long_se0_flag = long_se0_hit;
    wire timer_timeout_flag = events.timer_timeout;

    always_comb begin
        flag_set = '0;
        flag_set[BIT_ID] = id_pin_changed;
        flag_set[BIT_A_VBUS] = a_vbus_valid_changed;
        flag_set[BIT_B_END] = b_session_end_changed;
        flag_set[BIT_A_SESS] = a_session_valid_changed;
        flag_set[BIT_B_SESS] = b_session_valid_changed;
        flag_set[BIT_RMT] = remote_connect_changed;
        flag_set[BIT_SUSPEND] = suspend_flag;
        flag_set[BIT_RESUME] = resume_flag;
        flag_set[BIT_SRP] = session_request_flag;
        flag_set[BIT_SE0] = long_se0_flag;
        flag_set[BIT_TIMER] = timer_timeout_flag;
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_flags = bus_req.wr && (bus_req.addr == CMD_FLAGS_WR);
    wire wr_irq_en = bus_req.wr && (bus_req.addr == CMD_IRQ_EN_WR);
    wire rd_flags = bus_req.rd && (bus_req.addr == CMD_FLAGS_RD);
    wire rd_irq_en = bus_req.rd && (bus_req.addr == CMD_IRQ_EN_RD);
    wire rd_status = bus_req.rd && (bus_req.addr == CMD_STATUS_RD);
    wire rd_pending = bus_req.rd && (bus_req.addr == CMD_PENDING_RD);

    // ------------------------------------------------------------
    // event flags, write one to clear
    // ------------------------------------------------------------
    // zero bits of the write leave their flag alone; a set in the
    // same cycle as its clear wins so no event is lost
    wire [DATA_W-1:0] flags_clr = wr_flags ? (bus_req.wdata & EVENT_MASK) : '0;
    wire [DATA_W-1:0] flags_setv = DATA_W'(flag_set);

    wire [DATA_W-1:0] flags_keep = flags_r & ~flags_clr;

    assign flags_nxt = flags_keep | flags_setv;

    always_ff @(posedge clk) begin
        if (srst) begin
            flags_r <= FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ------------------------------------------------------------
    // interrupt enable register
    // ------------------------------------------------------------
    // reserved bits 15..11 are not stored and read as zero
    assign irq_en_nxt = wr_irq_en ? (bus_req.wdata & EVENT_MASK) : irq_en_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_en_r <= IRQ_EN_RESET;
        end else begin
            irq_en_r <= irq_en_nxt;
        end
    end

    // next-state enables so the request moves with the enable write
    wire timer_timeout_irq_en = irq_en_nxt[BIT_TIMER];
    wire long_se0_irq_en = irq_en_nxt[BIT_SE0];
    wire session_request_irq_en = irq_en_nxt[BIT_SRP];
    wire resume_irq_en = irq_en_nxt[BIT_RESUME];
    wire suspend_irq_en = irq_en_nxt[BIT_SUSPEND];
    wire remote_connect_irq_en = irq_en_nxt[BIT_RMT];
    wire b_session_valid_irq_en = irq_en_nxt[BIT_B_SESS];
    wire a_session_valid_irq_en = irq_en_nxt[BIT_A_SESS];
    wire b_session_end_irq_en = irq_en_nxt[BIT_B_END];
    wire a_vbus_valid_irq_en = irq_en_nxt[BIT_A_VBUS];
    wire id_pin_irq_en = irq_en_nxt[BIT_ID];

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    // gated on next-state values so the request moves with the flag
    wire [DATA_W-1:0] pending = flags_r & irq_en_r;

    wire pend_timer = flags_nxt[BIT_TIMER] && timer_timeout_irq_en;
    wire pend_se0 = flags_nxt[BIT_SE0] && long_se0_irq_en;
    wire pend_srp = flags_nxt[BIT_SRP] && session_request_irq_en;
    wire pend_resume = flags_nxt[BIT_RESUME] && resume_irq_en;
    wire pend_suspend = flags_nxt[BIT_SUSPEND] && suspend_irq_en;
    wire pend_rmt = flags_nxt[BIT_RMT] && remote_connect_irq_en;
    wire pend_b_sess = flags_nxt[BIT_B_SESS] && b_session_valid_irq_en;
    wire pend_a_sess = flags_nxt[BIT_A_SESS] && a_session_valid_irq_en;
    wire pend_b_end = flags_nxt[BIT_B_END] && b_session_end_irq_en;
    wire pend_a_vbus = flags_nxt[BIT_A_VBUS] && a_vbus_valid_irq_en;
    wire pend_id = flags_nxt[BIT_ID] && id_pin_irq_en;

    assign otg_irq_nxt = pend_timer | pend_se0 | pend_srp | pend_resume
        | pend_suspend | pend_rmt | pend_b_sess | pend_a_sess
        | pend_b_end | pend_a_vbus | pend_id;

    always_ff @(posedge clk) begin
        if (srst) begin
            otg_irq_r <= 1'b0;
        end else begin
            otg_irq_r <= otg_irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire [DATA_W-1:0] status_word =
        DATA_W'({suspended_r, levels_sync});

    // each source gated by its own decode; a new code is one more word
    wire [DATA_W-1:0] word_flags = rd_flags ? flags_r : '0;
    wire [DATA_W-1:0] word_irq_en = rd_irq_en ? irq_en_r : '0;
    wire [DATA_W-1:0] word_status = rd_status ? status_word : '0;
    wire [DATA_W-1:0] word_pending = rd_pending ? pending : '0;
    wire rd_mapped = rd_flags || rd_irq_en || rd_status || rd_pending;

    // unmapped reads and idle cycles return the idle word
    assign rdata_nxt = rd_mapped
        ? (word_flags | word_irq_en | word_status | word_pending)
        : RDATA_IDLE;

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= RDATA_IDLE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;
    assign otg_irq = otg_irq_r;
endmodule // oef_top

// ---- tb/oef_properties.sv ----
`timescale 1ns/1ns
module oef_checker #(
    parameter int LONG_SE0_CYCLES = 200000,
    parameter int IDLE_SUSPEND_CYCLES = 300000
) (
    input wire logic clk,
    input wire logic srst,
    input wire oef_pkg::oef_bus_req_t bus_req,
    input wire logic [oef_pkg::DATA_W-1:0] rdata,
    input wire oef_pkg::oef_levels_t levels_async,
    input wire oef_pkg::oef_events_t events,
    input wire logic dp_pin,
    input wire logic dm_pin,
    input wire logic otg_irq
);
    import oef_pkg::*;
    // ----
    // shadow of the enable register
    // ----
    // line detectors can fire late, so a clear only proves quiet after both times
    localparam int QUIET_MIN = LONG_SE0_CYCLES + IDLE_SUSPEND_CYCLES + 8;
    logic [15:0] en_r;
    logic [15:0] en_nxt;
    logic [2:0] post_r;
    int quiet_r;
    wire en_wr = bus_req.wr && (bus_req.addr == CMD_IRQ_EN_WR);
    wire fl_wr = bus_req.wr && (bus_req.addr == CMD_FLAGS_WR);
    wire settled = (post_r == 3'h4);
    assign en_nxt = en_wr ? (bus_req.wdata & EVENT_MASK) : en_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            en_r <= IRQ_EN_RESET;
            post_r <= 3'h0;
            quiet_r <= 0;
        end else begin
            en_r <= en_nxt;
            post_r <= settled ? post_r : post_r + 3'h1;
            quiet_r <= $changed({levels_async, dp_pin, dm_pin}) ? 0 :
                (quiet_r < QUIET_MIN) ? quiet_r + 1 : quiet_r;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_no_wr;
        (!bus_req.wr)[*5];
    endsequence

    property p_rd_idle;
        !bus_req.rd |=> rdata == RDATA_IDLE;
    endproperty
    property p_en_read;
        bus_req.rd && bus_req.addr == CMD_IRQ_EN_RD |=> rdata == $past(en_r);
    endproperty
    property p_reserved;
        bus_req.rd |=> rdata[15:11] == 5'h00;
    endproperty
    property p_timer_irq;
        events.timer_timeout && en_nxt[BIT_TIMER] |=> otg_irq;
    endproperty
    property p_srp_irq;
        events.session_request && en_nxt[BIT_SRP] |=> otg_irq;
    endproperty
    property p_no_en;
        en_r == 16'h0000 |-> !otg_irq;
    endproperty
    property p_w0_keep;
        fl_wr && bus_req.wdata == 16'h0000 && otg_irq |=> otg_irq;
    endproperty
    property p_clear_all;
        fl_wr && bus_req.wdata[10:0] == 11'h7FF && events == 2'b00 && quiet_r >= QUIET_MIN
            |=> !otg_irq;
    endproperty
    property p_lvl_irq(int b);
        $changed(levels_async[b]) && en_r[b] && settled ##1 s_no_wr |-> otg_irq;
    endproperty

    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    a_en_read: assert property (p_en_read) else $error("enable read wrong");
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    a_timer_irq: assert property (p_timer_irq) else $error("no timer irq");
    a_srp_irq: assert property (p_srp_irq) else $error("no session irq");
    a_no_en: assert property (p_no_en) else $error("irq while disabled");
    a_w0_keep: assert property (p_w0_keep) else $error("zero write cleared");
    a_clear_all: assert property (p_clear_all) else $error("irq after clear");
    a_lvl_irq_id: assert property (p_lvl_irq(BIT_ID)) else $error("no id irq");
    a_lvl_irq_vbus: assert property (p_lvl_irq(BIT_A_VBUS)) else $error("no vbus irq");
    a_lvl_irq_end: assert property (p_lvl_irq(BIT_B_END)) else $error("no end irq");

    c_timer: cover property (events.timer_timeout && en_nxt[BIT_TIMER]);
    c_level: cover property ($changed(levels_async) && settled);
    c_clear: cover property (fl_wr && otg_irq);
endmodule // oef_checker

bind oef_top oef_checker #(
    .LONG_SE0_CYCLES(LONG_SE0_CYCLES),
    .IDLE_SUSPEND_CYCLES(IDLE_SUSPEND_CYCLES)
) u_checker (
    .clk(clk),
    .srst(srst),
    .bus_req(bus_req),
    .rdata(rdata),
    .levels_async(levels_async),
    .events(events),
    .dp_pin(dp_pin),
    .dm_pin(dm_pin),
    .otg_irq(otg_irq)
);

// ---- tb/otg_event_flags_and_enables_test.sv ----
`timescale 1ns/1ns
module otg_event_flags_and_enables_test;
    import oef_pkg::*;
    localparam int SE0_N = 20;
    localparam int IDLE_N = 30;
    localparam int CYCLE_LIMIT = 6000;
    logic clk = 1'b0;
    logic srst = 1'b1;
    oef_bus_req_t bus_req = '0;
    logic [DATA_W-1:0] rdata;
    oef_levels_t levels_async = '0;
    oef_events_t events = '0;
    logic dp_pin = 1'b0;
    logic dm_pin = 1'b1;
    logic otg_irq;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 29690;
    logic [15:0] got;
    logic [15:0] rnd;

    always #5 clk = ~clk;

    oef_top #(
        .LONG_SE0_CYCLES(SE0_N),
        .IDLE_SUSPEND_CYCLES(IDLE_N)
    ) u_dut (
        .clk(clk),
        .srst(srst),
        .bus_req(bus_req),
        .rdata(rdata),
        .levels_async(levels_async),
        .events(events),
        .dp_pin(dp_pin),
        .dm_pin(dm_pin),
        .otg_irq(otg_irq)
    );

    // ----
    // shared tasks
    // ----
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] act);
        check_count++;
        if (act !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
        end
    endtask

    task automatic check_irq(input logic exp);
        check("otg_irq", {15'h0000, exp}, {15'h0000, otg_irq});
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    function automatic logic [15:0] flag_of(input int b);
        return 16'h0001 << b;
    endfunction

    // flag b alone is set; walk enable, zero write and one write against it
    task automatic exercise(input int b, input logic pre);
        bus_rd(CMD_FLAGS_RD, got);
        check("flags set", flag_of(b), got);
        check_irq(pre);
        bus_wr(CMD_IRQ_EN_WR, 16'h0000);
        check_irq(1'b0);
        rnd = 16'($random(seed));
        bus_wr(CMD_IRQ_EN_WR, (rnd & EVENT_MASK) | flag_of(b));
        check_irq(1'b1);
        bus_rd(CMD_PENDING_RD, got);
        check("pending", flag_of(b), got);
        bus_wr(CMD_FLAGS_WR, 16'h0000);
        check_irq(1'b1);
        bus_wr(CMD_FLAGS_WR, flag_of(b));
        check_irq(1'b0);
        bus_rd(CMD_FLAGS_RD, got);
        check("flags cleared", 16'h0000, got);
        bus_wr(CMD_IRQ_EN_WR, 16'h0000);
        $display("test event bit %0d done", b);
    endtask

    task automatic pulse(input oef_events_t e);
        @(posedge clk);
        events <= e;
        @(posedge clk);
        events <= '0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            err_count++;
            $display("CHECK FAILED cycle limit expected done seen running");
            close_out();
        end
    end

    // ----
    // main sequence
    // ----
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        bus_rd(CMD_IRQ_EN_RD, got);
        check("enable reset", IRQ_EN_RESET, got);
        bus_rd(CMD_FLAGS_RD, got);
        check("flags reset", FLAGS_RESET, got);
        check_irq(1'b0);
        for (int i = 0; i < 10; i++) begin
            rnd = (i == 0) ? 16'hFFFF : 16'($random(seed));
            bus_wr(CMD_IRQ_EN_WR, rnd);
            bus_wr(8'h5A, ~rnd);
            bus_rd(CMD_IRQ_EN_RD, got);
            check("enable readback", rnd & EVENT_MASK, got);
            bus_rd(8'h5A, got);
            check("unmapped read", 16'h0000, got);
        end
        bus_wr(CMD_IRQ_EN_WR, 16'h0000);
        bus_wr(CMD_FLAGS_WR, 16'h07FF);
        $display("test registers done");
        // both directions of every level change
        for (int pass = 0; pass < 2; pass++) begin
            for (int b = 0; b < NUM_LEVELS; b++) begin
                bus_wr(CMD_IRQ_EN_WR, (b < 3) ? flag_of(b) : 16'h0000);
                @(posedge clk);
                levels_async[b] <= ~levels_async[b];
                repeat (8) @(posedge clk);
                bus_rd(CMD_STATUS_RD, got);
                check("status", {10'h000, levels_async}, got);
                exercise(b, b < 3);
            end
        end
        bus_wr(CMD_IRQ_EN_WR, 16'h0400);
        pulse(2'b10);
        exercise(BIT_TIMER, 1'b1);
        // event and its clear in one cycle: the set must survive
        @(posedge clk);
        bus_req <= '{addr: CMD_FLAGS_WR, wdata: flag_of(BIT_TIMER), wr: 1'b1, rd: 1'b0};
        events <= 2'b10;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        events <= '0;
        bus_rd(CMD_FLAGS_RD, got);
        check("set beats clear", flag_of(BIT_TIMER), got);
        bus_wr(CMD_FLAGS_WR, flag_of(BIT_TIMER));
        bus_rd(CMD_FLAGS_RD, got);
        check("late clear", 16'h0000, got);
        $display("test set against clear done");
        bus_wr(CMD_IRQ_EN_WR, 16'h0100);
        pulse(2'b01);
        exercise(BIT_SRP, 1'b1);
        @(posedge clk);
        {dp_pin, dm_pin} <= 2'b00;
        repeat (SE0_N + 10) @(posedge clk);
        exercise(BIT_SE0, 1'b0);
        @(posedge clk);
        {dp_pin, dm_pin} <= 2'b10;
        repeat (IDLE_N + 10) @(posedge clk);
        bus_rd(CMD_STATUS_RD, got);
        check("status suspended", {9'h000, 1'b1, levels_async}, got);
        exercise(BIT_SUSPEND, 1'b0);
        @(posedge clk);
        {dp_pin, dm_pin} <= 2'b01;
        repeat (8) @(posedge clk);
        bus_rd(CMD_STATUS_RD, got);
        check("status resumed", {10'h000, levels_async}, got);
        exercise(BIT_RESUME, 1'b0);
        close_out();
    end
endmodule // otg_event_flags_and_enables_test
